// file: bench/rtcs_slow_src.sv
// Slow clock source that stands in for the oscillator feeding the counter.
module rtcs_slow_src (
    input wire logic run_in,
    output logic rtc_clk_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Toggles every 40 ns while running, so the bus clock is eight times faster.
    initial rtc_clk_out = 1'h0;
    always begin
        #40;
        rtc_clk_out = run_in ? ~rtc_clk_out : 1'h0;
    end
endmodule

// file: bench/tb.sv
// Self-checking testbench for the counter and tick timer block.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rtcs_pkg::*;
    logic clk_in = 1'h0;
    logic reset_in = 1'h1;
    rtcs_apb_req_type req = '0;
    logic [31:0] prdata;
    logic pready, pslverr, rtc_clk, c_irq, t_irq, tick, wrap_ev, match_ev;
    logic halted = 1'h0;
    logic standby = 1'h0;
    logic idle = 1'h0;
    logic [7:0] rd, first;
    logic err;
    int errors = 0;
    int n_tests = 0;
    int i;
    // Bus clock of 100 MHz.
    always #5 clk_in = ~clk_in;
    rtcs_slow_src src_u (.run_in(1'h1), .rtc_clk_out(rtc_clk));
    rtcs_timer dut_u (.clk_in(clk_in), .reset_in(reset_in), .apb_req_in(req),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .rtc_clk_in(rtc_clk), .cpu_halted_in(halted), .sleep_idle_in(idle),
        .sleep_standby_in(standby), .counter_irq_out(c_irq), .tick_irq_out(t_irq),
        .tick_out(tick), .wrap_event_out(wrap_ev), .match_event_out(match_ev));
    // Compares a byte and counts the outcome.
    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Compares a single bit and counts the outcome.
    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask
    // One APB transfer: setup, then access held until pready is sampled high.
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        int k;
        @(posedge clk_in);
        req <= '{1'h1, 1'h0, wr, {idx, 2'h0}, {24'h000000, wd}};
        @(posedge clk_in);
        req.penable <= 1'h1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_in);
            if (pready === 1'h1) break;
        end
        rd = prdata[7:0];
        err = pslverr;
        req <= '0;
    endtask
    // Polls a status bit until it clears, so a guarded register is not rewritten early.
    task automatic wait_clear(input logic [5:0] idx, input int b);
        int k;
        for (k = 0; k < 40; k++) begin
            xfer(1'h0, idx, 8'h00);
            if (rd[b] === 1'h0) break;
        end
        chk_bit("busy clear", 1'h0, rd[b]);
    endtask
    // Writes a sixteen-bit register low byte first and follows its crossing.
    task automatic wr16(input logic [5:0] idx, input logic [15:0] v, input int b);
        xfer(1'h1, idx, v[7:0]);
        xfer(1'h1, idx + 6'h01, v[15:8]);
        xfer(1'h0, RTCS_IDX_SYNC_STATUS, 8'h00);
        chk_bit("busy set", 1'h1, rd[b]);
        wait_clear(RTCS_IDX_SYNC_STATUS, b);
    endtask
    // Reset values, byte-latch reads and an unmapped index.
    task automatic t_reset();
        xfer(1'h0, RTCS_IDX_WRAP_LO, 8'h00);
        chk_byte("wrap lo", 8'hFF, rd);
        xfer(1'h0, RTCS_IDX_WRAP_HI, 8'h00);
        chk_byte("wrap hi", 8'hFF, rd);
        xfer(1'h0, RTCS_IDX_MAIN_CONTROL, 8'h00);
        chk_byte("control", 8'h00, rd);
        chk_bit("slverr ok", 1'h0, err);
        xfer(1'h0, 6'h0E, 8'h00);
        chk_bit("slverr bad", 1'h1, err);
    endtask
    // Wrap and match flags, enables, request and write-one-to-clear.
    task automatic t_wrap();
        idle <= 1'h1;
        wr16(RTCS_IDX_WRAP_LO, 16'h0003, RTCS_SYNC_WRAP);
        wr16(RTCS_IDX_MATCH_LO, 16'h0002, RTCS_SYNC_MATCH);
        xfer(1'h1, RTCS_IDX_INT_ENABLE, 8'h01);
        xfer(1'h1, RTCS_IDX_MAIN_CONTROL, 8'h01);
        wait_clear(RTCS_IDX_SYNC_STATUS, RTCS_SYNC_CONTROL_A);
        for (i = 0; i < 400 && wrap_ev !== 1'h1; i++) @(posedge clk_in);
        chk_bit("wrap event", 1'h1, wrap_ev);
        @(posedge clk_in);
        chk_bit("counter irq", 1'h1, c_irq);
        for (i = 0; i < 60 && match_ev !== 1'h1; i++) @(posedge clk_in);
        chk_bit("match event", 1'h1, match_ev);
        xfer(1'h0, RTCS_IDX_INT_FLAGS, 8'h00);
        chk_byte("flags", 8'h03, rd);
        xfer(1'h1, RTCS_IDX_MAIN_CONTROL, 8'h00);
        wait_clear(RTCS_IDX_SYNC_STATUS, RTCS_SYNC_CONTROL_A);
        chk_bit("irq held", 1'h1, c_irq);
        xfer(1'h1, RTCS_IDX_INT_FLAGS, 8'h01);
        xfer(1'h0, RTCS_IDX_INT_FLAGS, 8'h00);
        chk_byte("flags cleared", 8'h02, rd);
        chk_bit("irq off", 1'h0, c_irq);
        idle <= 1'h0;
    endtask
    // Count stays still in standby without run enable and while halted.
    task automatic t_freeze(input logic sb, input logic hl);
        standby <= sb;
        halted <= hl;
        xfer(1'h0, RTCS_IDX_COUNT_LO, 8'h00);
        first = rd;
        // Exactly six slow edges pass between the two samples, not a whole number of four-edge wrap laps.
        repeat (45) @(posedge clk_in);
        xfer(1'h0, RTCS_IDX_COUNT_LO, 8'h00);
        chk_byte("frozen count", first, rd);
    endtask
    // Halts with the tick at the given level, clears its flag, releases and reads the flag.
    task automatic t_restart(input logic lvl);
        for (i = 0; i < 200 && tick !== lvl; i++) @(posedge clk_in);
        halted <= 1'h1;
        xfer(1'h1, RTCS_IDX_TICK_INT_FLAGS, 8'h01);
        chk_bit("tick halted", 1'h0, tick);
        halted <= 1'h0;
        xfer(1'h0, RTCS_IDX_TICK_INT_FLAGS, 8'h00);
        chk_bit("restart flag", lvl, rd[0]);
    endtask
    // Tick interval interrupt, then halts taken at a high and at a low tick level.
    task automatic t_tick();
        xfer(1'h1, RTCS_IDX_TICK_INT_ENABLE, 8'h01);
        xfer(1'h1, RTCS_IDX_TICK_CONTROL, 8'h09);
        xfer(1'h0, RTCS_IDX_TICK_STATUS, 8'h00);
        chk_bit("tick busy", 1'h1, rd[0]);
        wait_clear(RTCS_IDX_TICK_STATUS, 0);
        for (i = 0; i < 400 && t_irq !== 1'h1; i++) @(posedge clk_in);
        chk_bit("tick irq", 1'h1, t_irq);
        t_restart(1'h1);
        t_restart(1'h0);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence after two cycles of reset.
    initial begin
        repeat (2) @(posedge clk_in);
        reset_in <= 1'h0;
        t_reset();
        t_wrap();
        xfer(1'h1, RTCS_IDX_MAIN_CONTROL, 8'h01);
        wait_clear(RTCS_IDX_SYNC_STATUS, RTCS_SYNC_CONTROL_A);
        t_freeze(1'h1, 1'h0);
        t_freeze(1'h0, 1'h1);
        @(posedge clk_in);
        halted <= 1'h0;
        t_tick();
        summarize();
    end
    // Cuts a hang short well beyond the expected run time.
    initial begin
        #200000;
        errors++;
        summarize();
    end
endmodule

// file: include/rtcs_pkg.sv
// Package with the register map, field layout and constants of the counter and tick timer.
package rtcs_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] RTCS_IDX_MAIN_CONTROL = 6'h00;
    localparam logic [5:0] RTCS_IDX_SYNC_STATUS = 6'h01;
    localparam logic [5:0] RTCS_IDX_INT_ENABLE = 6'h02;
    localparam logic [5:0] RTCS_IDX_INT_FLAGS = 6'h03;
    localparam logic [5:0] RTCS_IDX_BYTE_LATCH = 6'h04;
    localparam logic [5:0] RTCS_IDX_HALT_CONTROL = 6'h05;
    localparam logic [5:0] RTCS_IDX_DRIFT_TRIM = 6'h06;
    localparam logic [5:0] RTCS_IDX_SOURCE_SELECT = 6'h07;
    localparam logic [5:0] RTCS_IDX_COUNT_LO = 6'h08;
    localparam logic [5:0] RTCS_IDX_COUNT_HI = 6'h09;
    localparam logic [5:0] RTCS_IDX_WRAP_LO = 6'h0A;
    localparam logic [5:0] RTCS_IDX_WRAP_HI = 6'h0B;
    localparam logic [5:0] RTCS_IDX_MATCH_LO = 6'h0C;
    localparam logic [5:0] RTCS_IDX_MATCH_HI = 6'h0D;
    localparam logic [5:0] RTCS_IDX_TICK_CONTROL = 6'h10;
    localparam logic [5:0] RTCS_IDX_TICK_STATUS = 6'h11;
    localparam logic [5:0] RTCS_IDX_TICK_INT_ENABLE = 6'h12;
    localparam logic [5:0] RTCS_IDX_TICK_INT_FLAGS = 6'h13;
    localparam logic [5:0] RTCS_IDX_TICK_HALT_CONTROL = 6'h15;

    // Field positions inside the byte registers.
    localparam int RTCS_BIT_COUNTER_ENABLE = 0;
    localparam int RTCS_BIT_DRIFT_CORR_ENABLE = 2;
    localparam int RTCS_BIT_PRESCALE_LSB = 3;
    localparam int RTCS_BIT_STANDBY_RUN_ENABLE = 7;
    localparam int RTCS_BIT_TICK_ENABLE = 0;
    localparam int RTCS_BIT_PERIOD_LSB = 3;
    localparam int RTCS_BIT_WRAP = 0;
    localparam int RTCS_BIT_MATCH = 1;

    // Synchroniser channels; channels 0 to 3 are also the bit positions in the sync status register.
    localparam int RTCS_SYNC_CONTROL_A = 0;
    localparam int RTCS_SYNC_COUNT = 1;
    localparam int RTCS_SYNC_WRAP = 2;
    localparam int RTCS_SYNC_MATCH = 3;
    localparam int RTCS_SYNC_TICK = 4;
    localparam int RTCS_SYNC_CHANNELS = 5;

    // Values after reset.
    localparam logic [7:0] RTCS_BYTE_RESET = 8'h00;
    localparam logic [15:0] RTCS_WRAP_RESET = 16'hFFFF;
    localparam logic [15:0] RTCS_WORD_RESET = 16'h0000;

    // Slow clock edges a write needs to cross into the slow domain.
    localparam logic [1:0] RTCS_SYNC_EDGES = 2'h2;
    localparam int RTCS_PRESCALE_WIDTH = 15;

    // Request half of the APB slave port.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } rtcs_apb_req_type;

endpackage

// file: rtl/rtcs_timer.sv
// Real-time counter with periodic tick timer, interrupt flags, sleep, sync and halt logic.
// Function
// - Wrap event when count passes wrap limit
// - Match event when count equals match value
// - Tick event each selected tick interval
// - Flags set regardless of enable bits
// - Each source has its own enable
// - Request held while enabled flag stays set
// - Separate flag and enable registers per function
// - Counter keeps running in idle sleep
// - Standby running only with standby run enable
// - Tick timer runs in every sleep mode
// - Writes take effect after slow-domain sync
// - Busy bits for match, wrap, count, control
// - Busy bit for tick control writes
// - Halt bypass keeps counter running in halt
// - Halted counter freezes and ignores events
// - Tick halt bypass keeps tick running
// - Halted tick output forced low
// - High tick at halt gives extra interrupt
// - Low tick at halt resumes quietly
// - Writing one clears a flag
// - Prescaler stops when both functions off
// - Tick interval powers of two, 4..32768
// - Tick output toggles every half period
//
// Implementation choice: register access over APB.
module rtcs_timer (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire rtcs_pkg::rtcs_apb_req_type apb_req_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic rtc_clk_in,
    input wire logic cpu_halted_in,
    input wire logic sleep_idle_in,
    input wire logic sleep_standby_in,
    output logic counter_irq_out,
    output logic tick_irq_out,
    output logic tick_out,
    output logic wrap_event_out,
    output logic match_event_out
);
    import rtcs_pkg::*;

    logic [5:0] idx;
    logic idx_ok;
    logic setup, wr_acc, rd_acc;
    logic [7:0] wbyte;
    logic [7:0] main_control_stg_r, main_control_r, int_en_r, latch_r, halt_r, trim_r, srcsel_r;
    logic [7:0] tctl_stg_r, tctl_r, tick_en_r, tick_halt_r;
    logic [15:0] cnt_stg_r, per_stg_r, cmp_stg_r, cnt_r, per_r, cmp_r;
    logic [1:0] pend_r [RTCS_SYNC_CHANNELS];
    logic [RTCS_SYNC_CHANNELS-1:0] busy, apply;
    logic [1:0] cnt_flags_r;
    logic tick_flag_r;
    logic [31:0] prdata_r;
    logic rtc_d_r, rise;
    logic [RTCS_PRESCALE_WIDTH-1:0] psc_r, psc_nxt;
    logic cnt_active, tick_active, count_tick;
    logic [15:0] cnt_nxt;
    logic wrap_ev_r, match_ev_r, tick_lvl_r, tick_ev;
    logic [3:0] period;

    // Mask of low prescaler bits that must all be one for a count tick.
    function automatic logic [RTCS_PRESCALE_WIDTH-1:0] psc_mask(input logic [3:0] sel);
        logic [15:0] m;
        m = (16'h0001 << sel) - 16'h0001;
        return m[RTCS_PRESCALE_WIDTH-1:0];
    endfunction

    // True when an access targets the given register index.
    function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
        return a == b;
    endfunction

    // Bus decode; every register sits in one aligned word.
    assign idx = apb_req_in.paddr[7:2];
    assign wbyte = apb_req_in.pwdata[7:0];
    assign setup = apb_req_in.psel && !apb_req_in.penable;
    assign wr_acc = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && idx_ok;
    assign rd_acc = setup && !apb_req_in.pwrite && idx_ok;
    assign idx_ok = (apb_req_in.paddr[1:0] == 2'h0) &&
        ((idx <= RTCS_IDX_MATCH_HI) || (idx >= RTCS_IDX_TICK_CONTROL &&
        idx <= RTCS_IDX_TICK_HALT_CONTROL && idx != 6'h14));
    assign pready_out = 1'b1;
    assign pslverr_out = apb_req_in.psel && apb_req_in.penable && !idx_ok;
    assign prdata_out = prdata_r;

    // Slow clock is a synchronous input; its rising edge paces the slow logic.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rtc_d_r <= 1'b0;
        end else begin
            rtc_d_r <= rtc_clk_in;
        end
    end
    assign rise = rtc_clk_in && !rtc_d_r;

    // Read data is prepared in the setup cycle and held through the access phase.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup && !apb_req_in.pwrite) begin
            prdata_r <= 32'h0000_0000;
            case (idx)
                RTCS_IDX_MAIN_CONTROL: prdata_r[7:0] <= main_control_stg_r;
                RTCS_IDX_SYNC_STATUS: prdata_r[3:0] <= busy[3:0];
                RTCS_IDX_INT_ENABLE: prdata_r[1:0] <= int_en_r[1:0];
                RTCS_IDX_INT_FLAGS: prdata_r[1:0] <= cnt_flags_r;
                RTCS_IDX_BYTE_LATCH: prdata_r[7:0] <= latch_r;
                RTCS_IDX_HALT_CONTROL: prdata_r[0] <= halt_r[0];
                RTCS_IDX_DRIFT_TRIM: prdata_r[7:0] <= trim_r;
                RTCS_IDX_SOURCE_SELECT: prdata_r[1:0] <= srcsel_r[1:0];
                RTCS_IDX_COUNT_LO: prdata_r[7:0] <= cnt_r[7:0];
                RTCS_IDX_WRAP_LO: prdata_r[7:0] <= per_stg_r[7:0];
                RTCS_IDX_MATCH_LO: prdata_r[7:0] <= cmp_stg_r[7:0];
                RTCS_IDX_COUNT_HI, RTCS_IDX_WRAP_HI, RTCS_IDX_MATCH_HI: begin
                    prdata_r[7:0] <= latch_r;
                end
                RTCS_IDX_TICK_CONTROL: prdata_r[7:0] <= tctl_stg_r;
                RTCS_IDX_TICK_STATUS: prdata_r[0] <= busy[RTCS_SYNC_TICK];
                RTCS_IDX_TICK_INT_ENABLE: prdata_r[0] <= tick_en_r[0];
                RTCS_IDX_TICK_INT_FLAGS: prdata_r[0] <= tick_flag_r;
                RTCS_IDX_TICK_HALT_CONTROL: prdata_r[0] <= tick_halt_r[0];
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Byte latch: low-byte reads park the high byte in the same cycle as the low byte is
    // loaded, so the two halves of a live count come from one snapshot.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            latch_r <= RTCS_BYTE_RESET;
        end else if (wr_acc && (hit(idx, RTCS_IDX_BYTE_LATCH) || hit(idx, RTCS_IDX_COUNT_LO) ||
                hit(idx, RTCS_IDX_WRAP_LO) || hit(idx, RTCS_IDX_MATCH_LO))) begin
            latch_r <= wbyte;
        end else if (rd_acc) begin
            if (hit(idx, RTCS_IDX_COUNT_LO)) begin
                latch_r <= cnt_r[15:8];
            end else if (hit(idx, RTCS_IDX_WRAP_LO)) begin
                latch_r <= per_stg_r[15:8];
            end else if (hit(idx, RTCS_IDX_MATCH_LO)) begin
                latch_r <= cmp_stg_r[15:8];
            end
        end
    end

    // Plain bus-side registers that need no crossing.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            int_en_r <= RTCS_BYTE_RESET;
            halt_r <= RTCS_BYTE_RESET;
            trim_r <= RTCS_BYTE_RESET;
            srcsel_r <= RTCS_BYTE_RESET;
            tick_en_r <= RTCS_BYTE_RESET;
            tick_halt_r <= RTCS_BYTE_RESET;
        end else if (wr_acc) begin
            if (hit(idx, RTCS_IDX_INT_ENABLE)) int_en_r <= {6'h00, wbyte[1:0]};
            if (hit(idx, RTCS_IDX_HALT_CONTROL)) halt_r <= {7'h00, wbyte[0]};
            if (hit(idx, RTCS_IDX_DRIFT_TRIM)) trim_r <= wbyte;
            if (hit(idx, RTCS_IDX_SOURCE_SELECT)) srcsel_r <= {6'h00, wbyte[1:0]};
            if (hit(idx, RTCS_IDX_TICK_INT_ENABLE)) tick_en_r <= {7'h00, wbyte[0]};
            if (hit(idx, RTCS_IDX_TICK_HALT_CONTROL)) tick_halt_r <= {7'h00, wbyte[0]};
        end
    end

    // Staging copies written by software before they cross to the slow domain.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            main_control_stg_r <= RTCS_BYTE_RESET;
            tctl_stg_r <= RTCS_BYTE_RESET;
            cnt_stg_r <= RTCS_WORD_RESET;
            per_stg_r <= RTCS_WRAP_RESET;
            cmp_stg_r <= RTCS_WORD_RESET;
        end else if (wr_acc) begin
            if (hit(idx, RTCS_IDX_MAIN_CONTROL)) main_control_stg_r <= {wbyte[7:2], 1'b0, wbyte[0]};
            if (hit(idx, RTCS_IDX_TICK_CONTROL)) tctl_stg_r <= {1'b0, wbyte[6:3], 2'h0, wbyte[0]};
            if (hit(idx, RTCS_IDX_COUNT_HI)) cnt_stg_r <= {wbyte, latch_r};
            if (hit(idx, RTCS_IDX_WRAP_HI)) per_stg_r <= {wbyte, latch_r};
            if (hit(idx, RTCS_IDX_MATCH_HI)) cmp_stg_r <= {wbyte, latch_r};
        end
    end

    // Per-channel crossing counters: a write waits a fixed number of slow edges.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            for (int i = 0; i < RTCS_SYNC_CHANNELS; i++) begin
                pend_r[i] <= 2'h0;
            end
        end else begin
            for (int i = 0; i < RTCS_SYNC_CHANNELS; i++) begin
                if (pend_r[i] != 2'h0 && rise) begin
                    pend_r[i] <= pend_r[i] - 2'h1;
                end
            end
            if (wr_acc) begin
                if (hit(idx, RTCS_IDX_MAIN_CONTROL)) pend_r[RTCS_SYNC_CONTROL_A] <= RTCS_SYNC_EDGES;
                if (hit(idx, RTCS_IDX_COUNT_HI)) pend_r[RTCS_SYNC_COUNT] <= RTCS_SYNC_EDGES;
                if (hit(idx, RTCS_IDX_WRAP_HI)) pend_r[RTCS_SYNC_WRAP] <= RTCS_SYNC_EDGES;
                if (hit(idx, RTCS_IDX_MATCH_HI)) pend_r[RTCS_SYNC_MATCH] <= RTCS_SYNC_EDGES;
                if (hit(idx, RTCS_IDX_TICK_CONTROL)) pend_r[RTCS_SYNC_TICK] <= RTCS_SYNC_EDGES;
            end
        end
    end

    // Busy while a write is crossing; the value lands on the last slow edge.
    genvar g;
    generate
        for (g = 0; g < RTCS_SYNC_CHANNELS; g++) begin : g_sync
            assign busy[g] = pend_r[g] != 2'h0;
            assign apply[g] = rise && pend_r[g] == 2'h1;
        end
    endgenerate

    // Effective slow-domain copies of the control registers.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            main_control_r <= RTCS_BYTE_RESET;
            tctl_r <= RTCS_BYTE_RESET;
            per_r <= RTCS_WRAP_RESET;
            cmp_r <= RTCS_WORD_RESET;
        end else begin
            if (apply[RTCS_SYNC_CONTROL_A]) main_control_r <= main_control_stg_r;
            if (apply[RTCS_SYNC_TICK]) tctl_r <= tctl_stg_r;
            if (apply[RTCS_SYNC_WRAP]) per_r <= per_stg_r;
            if (apply[RTCS_SYNC_MATCH]) cmp_r <= cmp_stg_r;
        end
    end

    // Run conditions for sleep and debug halt.
    assign cnt_active = main_control_r[RTCS_BIT_COUNTER_ENABLE] &&
        !(cpu_halted_in && !halt_r[0]) &&
        !(sleep_standby_in && !main_control_r[RTCS_BIT_STANDBY_RUN_ENABLE]);
    assign tick_active = tctl_r[RTCS_BIT_TICK_ENABLE] &&
        !(cpu_halted_in && !tick_halt_r[0]);
    assign period = tctl_r[RTCS_BIT_PERIOD_LSB +: 4];

    // Shared prescaler runs while either function is active.
    assign psc_nxt = psc_r + 15'h0001;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            psc_r <= 15'h0000;
        end else if (rise && (cnt_active || tick_active)) begin
            psc_r <= psc_nxt;
        end
    end

    // Count tick when the selected low prescaler bits roll over.
    assign count_tick = rise && cnt_active &&
        ((psc_r & psc_mask(main_control_r[RTCS_BIT_PRESCALE_LSB +: 4])) ==
        psc_mask(main_control_r[RTCS_BIT_PRESCALE_LSB +: 4]));
    assign cnt_nxt = (cnt_r == per_r) ? 16'h0000 : cnt_r + 16'h0001;

    // Counter with wrap and match events; a crossed count write takes priority.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cnt_r <= RTCS_WORD_RESET;
            wrap_ev_r <= 1'b0;
            match_ev_r <= 1'b0;
        end else begin
            wrap_ev_r <= 1'b0;
            match_ev_r <= 1'b0;
            if (apply[RTCS_SYNC_COUNT]) begin
                cnt_r <= cnt_stg_r;
            end else if (count_tick) begin
                cnt_r <= cnt_nxt;
                wrap_ev_r <= cnt_r == per_r;
                match_ev_r <= cnt_nxt == cmp_r;
            end
        end
    end
    assign wrap_event_out = wrap_ev_r;
    assign match_event_out = match_ev_r;

    // Tick output is a prescaler bit, so it toggles every half interval.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tick_lvl_r <= 1'b0;
        end else if (tick_active && period != 4'h0 && period != 4'hF) begin
            tick_lvl_r <= psc_r[period];
        end else begin
            tick_lvl_r <= 1'b0;
        end
    end
    assign tick_out = tick_lvl_r;
    // A rising tick, including the one seen after a halt, is the tick event.
    assign tick_ev = tick_active && period != 4'h0 && period != 4'hF &&
        psc_r[period] && !tick_lvl_r;

    // Flags: events set them regardless of enable, a written one clears, set wins.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cnt_flags_r <= 2'h0;
            tick_flag_r <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == RTCS_BIT_WRAP && wrap_ev_r) || (i == RTCS_BIT_MATCH && match_ev_r)) begin
                    cnt_flags_r[i] <= 1'b1;
                end else if (wr_acc && hit(idx, RTCS_IDX_INT_FLAGS) && wbyte[i]) begin
                    cnt_flags_r[i] <= 1'b0;
                end
            end
            if (tick_ev) begin
                tick_flag_r <= 1'b1;
            end else if (wr_acc && hit(idx, RTCS_IDX_TICK_INT_FLAGS) && wbyte[0]) begin
                tick_flag_r <= 1'b0;
            end
        end
    end

    // Requests are levels held while an enabled flag remains set.
    assign counter_irq_out = |(cnt_flags_r & int_en_r[1:0]);
    assign tick_irq_out = tick_flag_r && tick_en_r[0];

    // Checks next to the logic.
    sequence s_flag_write(logic [5:0] r, int b);
        wr_acc && hit(idx, r) && wbyte[b];
    endsequence

    sequence s_quiet_flags;
        !wrap_ev_r && !match_ev_r && !tick_ev;
    endsequence

    a_wrap_to_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        wrap_ev_r |-> cnt_r == 16'h0000) else $error("wrap event without zero count");
    a_match_equal: assert property (@(posedge clk_in) disable iff (reset_in)
        match_ev_r |-> cnt_r == $past(cmp_r)) else $error("match event on unequal count");
    a_flag_sets: assert property (@(posedge clk_in) disable iff (reset_in)
        wrap_ev_r |=> cnt_flags_r[RTCS_BIT_WRAP]) else $error("wrap flag not set");
    a_tick_flag: assert property (@(posedge clk_in) disable iff (reset_in)
        tick_ev |=> tick_flag_r && tick_out) else $error("tick flag or level missing");
    a_irq_held: assert property (@(posedge clk_in) disable iff (reset_in)
        counter_irq_out && !(wr_acc && (hit(idx, RTCS_IDX_INT_FLAGS) ||
        hit(idx, RTCS_IDX_INT_ENABLE))) |=> counter_irq_out)
        else $error("request dropped with flag set");
    a_idle_runs: assert property (@(posedge clk_in) disable iff (reset_in)
        sleep_idle_in && main_control_r[RTCS_BIT_COUNTER_ENABLE] && !cpu_halted_in && !sleep_standby_in
        |-> cnt_active) else $error("counter stopped in idle");
    a_w1c_clear: assert property (@(posedge clk_in) disable iff (reset_in)
        s_flag_write(RTCS_IDX_TICK_INT_FLAGS, 0) and s_quiet_flags |=> !tick_flag_r)
        else $error("tick flag not cleared");
    a_busy_window: assert property (@(posedge clk_in) disable iff (reset_in)
        wr_acc && hit(idx, RTCS_IDX_MATCH_HI) |=> busy[RTCS_SYNC_MATCH] && $stable(cmp_r))
        else $error("match write not busy");
    a_tick_busy: assert property (@(posedge clk_in) disable iff (reset_in)
        $fell(busy[RTCS_SYNC_TICK]) |-> $past(rise) && tctl_r == tctl_stg_r)
        else $error("tick control landed wrongly");
    a_halt_freeze: assert property (@(posedge clk_in) disable iff (reset_in)
        cpu_halted_in && !halt_r[0] && !apply[RTCS_SYNC_COUNT] |=> $stable(cnt_r))
        else $error("counter moved while halted");
    a_tick_low: assert property (@(posedge clk_in) disable iff (reset_in)
        cpu_halted_in && !tick_halt_r[0] |=> !tick_out) else $error("tick high in halt");
    a_psc_stop: assert property (@(posedge clk_in) disable iff (reset_in)
        !cnt_active && !tick_active |=> $stable(psc_r)) else $error("prescaler ran while off");
    a_standby_stop: assert property (@(posedge clk_in) disable iff (reset_in)
        sleep_standby_in && !main_control_r[RTCS_BIT_STANDBY_RUN_ENABLE] && !apply[RTCS_SYNC_COUNT]
        |=> $stable(cnt_r)) else $error("counter ran in standby");

endmodule
